// >>> hw/rtcc_top.v
// time of day and day counters with scratch byte and oscillator stop flag
`timescale 1ns/1ps
`include "rtcc_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - scratch byte at 03h, resets zero
// - seconds bit 7 is oscillator stop flag
// - flag set while oscillator not running
// - flag stays set until host write clears
// - seconds bcd, tens 0-5, units 0-9
// - minutes bcd at 05h, bit 7 zero
// - 12-hour: meridiem bit 5, tens bit 4
// - 24-hour: tens bits 5-4, default zero
// - hour format chosen by control select bit
// - day of month bcd at 07h, default 1
// - year divisible by four gives february 29
// - weekday 0-6 at 08h, default saturday
// - counters frozen while host access in progress
// - one pending tick kept, applied after access
// - month end wrap pulses month_carry for one cycle
module rtcc_top (
  input wire clk,
  input wire rst,
  input wire tick_1hz,
  input wire osc_running,
  input wire hour_12_mode,
  input wire [4:0] month_bcd,
  input wire [7:0] year_bcd,
  input wire acc_busy,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  output reg month_carry
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg [7:0] scratch;
  reg osc_stop_flag;
  reg [6:0] seconds;
  reg [6:0] minutes;
  reg [5:0] hours;
  reg [5:0] days;
  reg [2:0] weekday;
  reg pending;

  wire wr_sec = wr_strobe && (addr == `RTCC_ADDR_SECONDS);
  wire wr_min = wr_strobe && (addr == `RTCC_ADDR_MINUTES);
  wire wr_hr = wr_strobe && (addr == `RTCC_ADDR_HOURS);
  wire wr_day = wr_strobe && (addr == `RTCC_ADDR_DAYS);
  wire wr_wd = wr_strobe && (addr == `RTCC_ADDR_WEEKDAYS);

  ////////////////////////////////////////////////////////////////////////////
  // calendar helpers
  function leap_year;
    input [7:0] yr;
    begin
      // bcd: even tens need units 0/4/8, odd tens need units 2/6
      if (yr[4] == 1'b0) begin
        leap_year = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
      end else begin
        leap_year = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
      end
    end
  endfunction

  function [7:0] month_len;
    input [4:0] mon;
    input leap;
    begin
      case (mon)
        `RTCC_FEB: month_len = leap ? `RTCC_DAYS_29 : `RTCC_DAYS_28;
        `RTCC_APR: month_len = `RTCC_DAYS_30;
        `RTCC_JUN: month_len = `RTCC_DAYS_30;
        `RTCC_SEP: month_len = `RTCC_DAYS_30;
        `RTCC_NOV: month_len = `RTCC_DAYS_30;
        default: month_len = `RTCC_DAYS_31;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next values of each counter
  wire [7:0] sec_next;
  wire sec_wrap;
  wire [7:0] min_next;
  wire min_wrap;
  wire [7:0] h24_next;
  wire h24_wrap;
  wire [7:0] h12_next;
  wire [7:0] day_next;
  wire day_wrap;
  wire [7:0] day_limit = month_len(month_bcd, leap_year(year_bcd));

  rtcc_bcd_step u_sec (
    .cur({1'b0, seconds}),
    .max_val(`RTCC_SEC_MAX),
    .min_val(`RTCC_ZERO),
    .nxt(sec_next),
    .wrap(sec_wrap)
  );

  rtcc_bcd_step u_min (
    .cur({1'b0, minutes}),
    .max_val(`RTCC_MIN_MAX),
    .min_val(`RTCC_ZERO),
    .nxt(min_next),
    .wrap(min_wrap)
  );

  rtcc_bcd_step u_h24 (
    .cur({2'b00, hours}),
    .max_val(`RTCC_H24_MAX),
    .min_val(`RTCC_ZERO),
    .nxt(h24_next),
    .wrap(h24_wrap)
  );

  // 12-hour count runs 12, 1 .. 11; meridiem handled alongside
  rtcc_bcd_step u_h12 (
    .cur({3'b000, hours[4:0]}),
    .max_val(`RTCC_H12_MAX),
    .min_val(`RTCC_ONE),
    .nxt(h12_next),
    .wrap()
  );

  rtcc_bcd_step u_day (
    .cur({2'b00, days}),
    .max_val(day_limit),
    .min_val(`RTCC_ONE),
    .nxt(day_next),
    .wrap(day_wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ripple of one increment
  wire do_step = !acc_busy && (tick_1hz || pending);
  wire h12_at_11 = (hours[4:0] == `RTCC_H12_LAST_AM);
  wire hr_carry_in = sec_wrap && min_wrap;
  wire day_carry_in = hr_carry_in &&
    (hour_12_mode ? (h12_at_11 && hours[`RTCC_MERIDIEM_BIT]) : h24_wrap);
  wire month_carry_in = day_carry_in && day_wrap;

  reg [5:0] hours_stepped;
  always @* begin
    if (hour_12_mode) begin
      hours_stepped = {hours[`RTCC_MERIDIEM_BIT] ^ h12_at_11, h12_next[4:0]};
    end else begin
      hours_stepped = h24_next[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clk) begin
    if (rst) begin
      scratch <= `RTCC_RST_SCRATCH;
      osc_stop_flag <= `RTCC_RST_OSC_STOP;
      seconds <= `RTCC_RST_SECONDS;
      minutes <= `RTCC_RST_MINUTES;
      hours <= `RTCC_RST_HOURS;
      days <= `RTCC_RST_DAYS;
      weekday <= `RTCC_RST_WEEKDAYS;
      pending <= 1'b0;
      month_carry <= 1'b0;
    end else begin
      // at most one tick remembered; a second during access is lost.
      // a tick landing on the edge that drains the pending one is kept
      if (tick_1hz && (acc_busy || pending)) begin
        pending <= 1'b1;
      end else if (do_step) begin
        pending <= 1'b0;
      end
      month_carry <= do_step && month_carry_in;
      if (wr_strobe && (addr == `RTCC_ADDR_SCRATCH)) begin
        scratch <= wdata;
      end
      // stopped oscillator wins over a clearing write
      if (!osc_running) begin
        osc_stop_flag <= 1'b1;
      end else if (wr_sec) begin
        osc_stop_flag <= wdata[`RTCC_OSC_STOP_BIT];
      end
      if (wr_sec) begin
        seconds <= wdata[6:0];
      end else if (do_step) begin
        seconds <= sec_next[6:0];
      end
      if (wr_min) begin
        minutes <= wdata[6:0];
      end else if (do_step && sec_wrap) begin
        minutes <= min_next[6:0];
      end
      if (wr_hr) begin
        hours <= wdata[5:0];
      end else if (do_step && hr_carry_in) begin
        hours <= hours_stepped;
      end
      if (wr_day) begin
        days <= wdata[5:0];
      end else if (do_step && day_carry_in) begin
        days <= day_next[5:0];
      end
      if (wr_wd) begin
        weekday <= wdata[2:0];
      end else if (do_step && day_carry_in) begin
        weekday <= (weekday >= `RTCC_WD_MAX) ? `RTCC_WD_FIRST : weekday + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; unused bits and unmapped addresses read zero
  always @(posedge clk) begin
    if (rst) begin
      rdata <= `RTCC_ZERO;
    end else if (rd_strobe) begin
      case (addr)
        `RTCC_ADDR_SCRATCH: rdata <= scratch;
        `RTCC_ADDR_SECONDS: rdata <= {osc_stop_flag, seconds};
        `RTCC_ADDR_MINUTES: rdata <= {1'b0, minutes};
        `RTCC_ADDR_HOURS: rdata <= {2'b00, hours};
        `RTCC_ADDR_DAYS: rdata <= {2'b00, days};
        `RTCC_ADDR_WEEKDAYS: rdata <= {5'h00, weekday};
        default: rdata <= `RTCC_ZERO;
      endcase
    end
  end

endmodule // rtcc_top

// >>> inc/rtcc_consts.vh
// constants for the time and date counter block
`ifndef RTCC_CONSTS_VH
`define RTCC_CONSTS_VH
`define RTCC_ADDR_SCRATCH 8'h03
`define RTCC_ADDR_SECONDS 8'h04
`define RTCC_ADDR_MINUTES 8'h05
`define RTCC_ADDR_HOURS 8'h06
`define RTCC_ADDR_DAYS 8'h07
`define RTCC_ADDR_WEEKDAYS 8'h08
`define RTCC_RST_SCRATCH 8'h00
`define RTCC_RST_SECONDS 7'h00
`define RTCC_RST_MINUTES 7'h00
`define RTCC_RST_HOURS 6'h00
`define RTCC_RST_DAYS 6'h01
`define RTCC_RST_WEEKDAYS 3'h6
`define RTCC_RST_OSC_STOP 1'b1
`define RTCC_OSC_STOP_BIT 7
`define RTCC_MERIDIEM_BIT 5
`define RTCC_SEC_MAX 8'h59
`define RTCC_MIN_MAX 8'h59
`define RTCC_H24_MAX 8'h23
`define RTCC_H12_MAX 8'h12
`define RTCC_H12_LAST_AM 5'h11
`define RTCC_ZERO 8'h00
`define RTCC_ONE 8'h01
`define RTCC_WD_MAX 3'h6
`define RTCC_WD_FIRST 3'h0
`define RTCC_FEB 5'h02
`define RTCC_APR 5'h04
`define RTCC_JUN 5'h06
`define RTCC_SEP 5'h09
`define RTCC_NOV 5'h11
`define RTCC_DAYS_28 8'h28
`define RTCC_DAYS_29 8'h29
`define RTCC_DAYS_30 8'h30
`define RTCC_DAYS_31 8'h31
`endif

// >>> hw/rtcc_bcd_step.v
// bcd counter step with wrap between a lowest and a highest value
`timescale 1ns/1ps
module rtcc_bcd_step (
  input wire [7:0] cur,
  input wire [7:0] max_val,
  input wire [7:0] min_val,
  output reg [7:0] nxt,
  output reg wrap
);
  // >= so an illegal written value still falls back into range
  always @* begin
    wrap = (cur >= max_val);
    if (wrap) begin
      nxt = min_val;
    end else if (cur[3:0] >= 4'h9) begin
      nxt = {cur[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {cur[7:4], cur[3:0] + 4'h1};
    end
  end
endmodule // rtcc_bcd_step

// >>> verif/rtcc_props.sv
// assertions on the counter block ports
`timescale 1ns/1ps
module rtcc_props (
  input wire clk,
  input wire rst,
  input wire tick_1hz,
  input wire osc_running,
  input wire hour_12_mode,
  input wire [4:0] month_bcd,
  input wire [7:0] year_bcd,
  input wire acc_busy,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire month_carry
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_UNMAPPED: assert property (rd_strobe && (addr < 8'h03 || addr > 8'h08) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MIN_TOP: assert property (rd_strobe && addr == 8'h05 |=> !rdata[7])
    else $error("minutes bit 7 set");
  AST_HOUR_TOP: assert property (rd_strobe && addr == 8'h06 |=> rdata[7:6] == 2'b00)
    else $error("hours top bits set");
  AST_DAY_TOP: assert property (rd_strobe && addr == 8'h07 |=> rdata[7:6] == 2'b00)
    else $error("days top bits set");
  AST_WDAY_TOP: assert property (rd_strobe && addr == 8'h08 |=> rdata[7:3] == 5'h00)
    else $error("weekday top bits set");
  AST_OSC_SET: assert property (!osc_running ##1 rd_strobe && addr == 8'h04 |=> rdata[7])
    else $error("stop flag clear while stopped");
  AST_CARRY_ONE: assert property (month_carry |=> !month_carry)
    else $error("carry longer than one cycle");
  AST_CARRY_FREE: assert property (month_carry |-> !$past(acc_busy))
    else $error("carry during access");
endmodule // rtcc_props

// >>> verif/rtcc_host.sv
// host side model issuing register accesses
`timescale 1ns/1ps
module rtcc_host (
  input wire clk,
  input wire [7:0] rdata,
  output reg acc_busy = 1'b0,
  output reg wr_strobe = 1'b0,
  output reg rd_strobe = 1'b0,
  output reg [7:0] addr = 8'h00,
  output reg [7:0] wdata = 8'h00
);
  // one byte per access, far inside a second
  task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk);
      acc_busy <= 1'b1;
      wr_strobe <= w;
      rd_strobe <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      @(posedge clk);
      acc_busy <= 1'b0;
      // rdata stands from the strobe edge on; no strobe at this edge
      q = rdata;
    end
  endtask
endmodule // rtcc_host

// >>> verif/tb.sv
// testbench for the time and date counter block
`timescale 1ns/1ps
module tb;
  reg clk, rst, tick_1hz, osc_running, hour_12_mode;
  reg [4:0] month_bcd;
  reg [7:0] year_bcd, q;
  wire acc_busy, wr_strobe, rd_strobe, month_carry;
  wire [7:0] addr, wdata, rdata;
  integer n_mismatch = 0, checks_done = 0, k;
  rtcc_top i_dut (.clk(clk), .rst(rst), .tick_1hz(tick_1hz), .osc_running(osc_running),
    .hour_12_mode(hour_12_mode), .month_bcd(month_bcd), .year_bcd(year_bcd),
    .acc_busy(acc_busy), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .addr(addr),
    .wdata(wdata), .rdata(rdata), .month_carry(month_carry));
  rtcc_host i_host (.clk(clk), .rdata(rdata), .acc_busy(acc_busy), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .addr(addr), .wdata(wdata));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      i_host.acc(1'b0, a, 8'h00, q);
      chk(q, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    i_host.acc(1'b1, a, d, q);
  endtask
  // always xx:59:59, so every tick ripples into hours, and into days from the last hour
  task set_time(input [7:0] h, input [7:0] d);
    begin
      wr(8'h04, 8'h59);
      wr(8'h05, 8'h59);
      wr(8'h06, h);
      wr(8'h07, d);
    end
  endtask
  // one tick; carry watched cycle by cycle, so a long or late pulse fails
  task tick(input [7:0] ncarry);
    begin
      @(posedge clk) tick_1hz <= 1'b1;
      @(posedge clk) tick_1hz <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        #1 chk({7'h00, month_carry}, (k == 0) ? ncarry : 8'h00);
        @(posedge clk);
      end
    end
  endtask
  ////////////////////////////////////////
  task t_defaults;
    begin
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h80);
      rd(8'h05, 8'h00);
      rd(8'h06, 8'h00);
      rd(8'h07, 8'h01);
      rd(8'h08, 8'h06);
    end
  endtask
  task t_scratch;
    begin
      wr(8'h03, 8'ha5);
      rd(8'h03, 8'ha5);
      rd(8'h0b, 8'h00);
    end
  endtask
  task t_osc_flag;
    begin
      wr(8'h04, 8'h00);
      rd(8'h04, 8'h80);
      @(posedge clk) osc_running <= 1'b1;
      wr(8'h04, 8'h00);
      rd(8'h04, 8'h00);
      // a one-cycle halt must set the flag again
      @(posedge clk) osc_running <= 1'b0;
      @(posedge clk) osc_running <= 1'b1;
      rd(8'h04, 8'h80);
      wr(8'h04, 8'h00);
      rd(8'h04, 8'h00);
    end
  endtask
  task t_rollover;
    begin
      set_time(8'h23, 8'h31);
      wr(8'h08, 8'h06);
      tick(8'h01);
      rd(8'h04, 8'h00);
      rd(8'h05, 8'h00);
      rd(8'h06, 8'h00);
      rd(8'h07, 8'h01);
      rd(8'h08, 8'h00);
    end
  endtask
  task t_month_len;
    begin
      @(posedge clk) month_bcd <= 5'h04;
      set_time(8'h23, 8'h30);
      tick(8'h01);
      rd(8'h07, 8'h01);
      @(posedge clk) month_bcd <= 5'h02;
      set_time(8'h23, 8'h28);
      tick(8'h00);
      rd(8'h07, 8'h29);
      set_time(8'h23, 8'h29);
      tick(8'h01);
      rd(8'h07, 8'h01);
      @(posedge clk) year_bcd <= 8'h12;
      set_time(8'h23, 8'h28);
      tick(8'h00);
      rd(8'h07, 8'h29);
      @(posedge clk) year_bcd <= 8'h00;
      set_time(8'h23, 8'h28);
      tick(8'h00);
      rd(8'h07, 8'h29);
      @(posedge clk) year_bcd <= 8'h23;
      set_time(8'h23, 8'h28);
      tick(8'h01);
      rd(8'h07, 8'h01);
    end
  endtask
  task t_hours12;
    begin
      @(posedge clk) hour_12_mode <= 1'b1;
      set_time(8'h11, 8'h05);
      tick(8'h00);
      rd(8'h06, 8'h32);
      rd(8'h07, 8'h05);
      set_time(8'h32, 8'h05);
      tick(8'h00);
      rd(8'h06, 8'h21);
      set_time(8'h31, 8'h05);
      tick(8'h00);
      rd(8'h06, 8'h12);
      rd(8'h07, 8'h06);
    end
  endtask
  // two ticks inside one access: only one may survive
  task t_blocked;
    begin
      wr(8'h04, 8'h10);
      fork
        i_host.acc(1'b0, 8'h04, 8'h00, q);
        begin
          @(posedge clk) tick_1hz <= 1'b1;
          repeat (2) @(posedge clk);
          tick_1hz <= 1'b0;
        end
      join
      chk(q, 8'h10);
      rd(8'h04, 8'h11);
    end
  endtask
  // reset in mid-run with every counter but minutes away from its default
  task t_mid_reset;
    begin
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  initial begin
    rst = 1;
    tick_1hz = 0;
    osc_running = 0;
    hour_12_mode = 0;
    month_bcd = 5'h01;
    year_bcd = 8'h24;
    repeat (8) @(posedge clk);
    rst <= 0;
    t_defaults;
    t_scratch;
    t_osc_flag;
    t_rollover;
    t_month_len;
    t_hours12;
    t_blocked;
    t_mid_reset;
    stop_test;
  end
endmodule // tb
bind rtcc_top rtcc_props i_props (.*);
